/* iec_pkg.sv */
// constants for the interrupt enable register block
package iec_pkg;
	localparam int IEC_AW = 16;
	localparam int IEC_DW = 32;
	localparam int IEC_NSRC = 32;
	// analog/timer enable register address as printed
	localparam logic [15:0] IEC_ADDR_ANALOG = 16'hF014;
	// serial/misc enable register, address of our own choosing
	localparam logic [15:0] IEC_ADDR_SERIAL = 16'hF012;
	// request flag register, set by write of ones, cleared by write of ones
	localparam logic [15:0] IEC_ADDR_REQ = 16'hF01C;
	localparam logic [15:0] IEC_ADDR_REQCLR = 16'hF01E;
	// control/status register: bit 0 master gate, bit 1 pending
	localparam logic [15:0] IEC_ADDR_CTRL = 16'hF020;
	localparam logic [15:0] IEC_RST_ENABLE = 16'h0000;
	localparam int IEC_CTRL_MASTER = 0;
	localparam int IEC_CTRL_PEND = 1;
	// serial/misc field positions
	localparam int IEC_SYNC_SERIAL0 = 0;
	localparam int IEC_SYNC_SERIAL0_FIFO = 1;
	localparam int IEC_TWOWIRE0 = 2;
	localparam int IEC_TWOWIRE1 = 3;
	localparam int IEC_UART0_RX = 4;
	localparam int IEC_UART0_TX = 5;
	localparam int IEC_UART0_TX_FIFO = 6;
	localparam int IEC_SLOW_CLOCK_SWITCH = 13;
	localparam int IEC_VOLTAGE_SUPERVISOR = 14;
	localparam int IEC_MELODY0 = 15;
	localparam logic [15:0] IEC_SERIAL_USED = 16'hE07F;
	// analog/timer field positions
	localparam int IEC_SAR_ADC = 0;
	localparam int IEC_RC_ADC = 1;
	localparam int IEC_COMPARATOR0 = 4;
	localparam int IEC_COMPARATOR1 = 5;
	localparam int IEC_BYTE_TIMER0 = 8;
	localparam logic [15:0] IEC_ANALOG_USED = 16'hFF33;
	// instructions to let pass after an enabling write
	localparam int IEC_DEFER_INSNS = 1;
endpackage

/* iec_enreg.sv */
`timescale 1ns/1ps
// one 16-bit enable register with byte-lane writes
module iec_enreg
	import iec_pkg::*;
#(
	parameter logic [15:0] RESET_VAL = 16'h0000
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr,
	input wire logic [1:0] lanes,
	input wire logic [15:0] wdata,
	output logic [15:0] value
);
	typedef struct packed {
		logic [15:0] value_r;
	} iec_enreg_s;
	iec_enreg_s st_r;
	iec_enreg_s st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		// a byte write leaves the other byte alone
		if (wr && lanes[0])
			st_nxt.value_r[7:0] = wdata[7:0];
		if (wr && lanes[1])
			st_nxt.value_r[15:8] = wdata[15:8];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '{value_r: RESET_VAL};
		else
			st_r <= st_nxt;
	end
	assign value = st_r.value_r;
endmodule

/* iec_defer.sv */
`timescale 1ns/1ps
// holds off a fresh pending condition for a number of instructions
module iec_defer
	import iec_pkg::*;
#(
	parameter int INSNS = 1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic arm,
	input wire logic insn_done,
	output logic hold
);
	typedef struct packed {
		logic [3:0] left_r;
	} iec_defer_s;
	iec_defer_s st_r;
	iec_defer_s st_nxt;
	// the counter is four bits wide
	if (INSNS < 1 || INSNS > 15)
	begin : g_bad_insns
		$error("iec_defer: INSNS out of range");
	end
	always_comb
	begin
		st_nxt = st_r;
		// an arming write restarts the count; it wins over a completion
		if (arm)
			st_nxt.left_r = 4'(INSNS);
		else if (insn_done && st_r.left_r != 4'h0)
			st_nxt.left_r = st_r.left_r - 4'h1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '{left_r: 4'h0};
		else
			st_r <= st_nxt;
	end
	assign hold = (st_r.left_r != 4'h0);
endmodule

/* iec_top.sv */
`timescale 1ns/1ps
// interrupt enable registers for serial/misc and analog/timer sources
// Behaviour
// - bit 0 of serial/misc enable gates sync serial 0; resets 0
// - bit 1 of serial/misc enable gates fifo sync serial 0
// - bits 2 and 3 gate two-wire bus 0 and 1
// - bits 4 and 5 gate uart0 receive and transmit
// - bit 6 gates uart0 fifo transmit
// - bit 13 gates slow clock switching
// - bit 14 gates voltage level supervisor
// - bit 15 gates melody generator 0
// - accepting an interrupt clears master gate, enables unchanged
// - analog/timer enable at F014, 8/16-bit access, resets 0000
// - bit 0 of analog/timer enable gates sar adc
// - bit 1 gates rc adc
// - bits 4 and 5 gate comparators 0 and 1
// - bit 8+n gates 8-bit timer n, n 0..7
// - request raised only when flag, enable and master gate all 1
// - request flag sets on event regardless of enables
// - request flag cleared by hardware on acceptance
// - enabling write defers transfer by one more instruction
module iec_top
	import iec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iec_pkg::IEC_AW-1:0] paddr,
	input wire logic [iec_pkg::IEC_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [iec_pkg::IEC_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] serial_events,
	input wire logic [15:0] analog_events,
	input wire logic insn_done,
	input wire logic irq_accept,
	input wire logic [4:0] irq_accept_id,
	output logic irq_request,
	output logic [4:0] irq_id,
	output logic master_irq_gate
);
	typedef struct packed {
		logic [31:0] req_r;
		logic master_r;
		logic [31:0] prdata_r;
		logic pslverr_r;
	} iec_top_s;
	iec_top_s st_r;
	iec_top_s st_nxt;
	logic [15:0] serial_en;
	logic [15:0] analog_en;
	logic [31:0] en_all;
	logic [31:0] used_mask;
	logic [31:0] live;
	logic [31:0] events_all;
	logic acc_phase;
	logic setup_phase;
	logic wr_acc;
	logic [1:0] lanes;
	logic hit_serial;
	logic hit_analog;
	logic hit_req;
	logic hit_reqclr;
	logic hit_ctrl;
	logic hit_any;
	logic en_write;
	logic hold;
	logic found;
	logic [4:0] pick;

	assign acc_phase = psel && penable;
	assign setup_phase = psel && !penable;
	assign wr_acc = acc_phase && pwrite;
	// 16-bit word in the low half; the two byte lanes map onto it
	assign lanes = pstrb[1:0];
	assign hit_serial = (paddr == IEC_ADDR_SERIAL);
	assign hit_analog = (paddr == IEC_ADDR_ANALOG);
	assign hit_req = (paddr == IEC_ADDR_REQ);
	assign hit_reqclr = (paddr == IEC_ADDR_REQCLR);
	assign hit_ctrl = (paddr == IEC_ADDR_CTRL);
	assign hit_any = hit_serial | hit_analog | hit_req | hit_reqclr
		| hit_ctrl;

	// the two enable registers; every bit is writable storage
	iec_enreg #(
		.RESET_VAL(IEC_RST_ENABLE)
	) u_serial (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr_acc && hit_serial),
		.lanes(lanes),
		.wdata(pwdata[15:0]),
		.value(serial_en)
	);
	iec_enreg #(
		.RESET_VAL(IEC_RST_ENABLE)
	) u_analog (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr_acc && hit_analog),
		.lanes(lanes),
		.wdata(pwdata[15:0]),
		.value(analog_en)
	);

	// unassigned positions never gate a source
	assign used_mask = {IEC_ANALOG_USED, IEC_SERIAL_USED};
	assign en_all = {analog_en, serial_en} & used_mask;
	assign events_all = {analog_events, serial_events} & used_mask;
	// a pending source with flag and enable and master all set
	assign live = st_r.req_r & en_all & {32{st_r.master_r}};

	// any write to an enable register or the request flag set register arms the delay; request clear writes do not
	assign en_write = wr_acc && (hit_serial || hit_analog || hit_req);
	iec_defer #(
		.INSNS(IEC_DEFER_INSNS)
	) u_defer (
		.pclk(pclk),
		.presetn(presetn),
		.arm(en_write),
		.insn_done(insn_done),
		.hold(hold)
	);

	// lowest numbered live source is reported first
	always_comb
	begin
		found = 1'b0;
		pick = 5'h00;
		for (int i = 0; i < IEC_NSRC; i++)
		begin
			if (!found && live[i])
			begin
				found = 1'b1;
				pick = 5'(i);
			end
		end
	end
	// held off while a fresh write still awaits its instruction
	assign irq_request = found && !hold && !en_write;
	assign irq_id = pick;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pslverr_r = 1'b0;
		// software writes to request and control registers
		if (wr_acc && hit_req)
		begin
			if (lanes[0])
				st_nxt.req_r[7:0] = st_r.req_r[7:0] | pwdata[7:0];
			if (lanes[1])
				st_nxt.req_r[15:8] = st_r.req_r[15:8] | pwdata[15:8];
			if (pstrb[2])
				st_nxt.req_r[23:16] = st_r.req_r[23:16] | pwdata[23:16];
			if (pstrb[3])
				st_nxt.req_r[31:24] = st_r.req_r[31:24] | pwdata[31:24];
		end
		if (wr_acc && hit_reqclr)
		begin
			for (int b = 0; b < 4; b++)
				if (pstrb[b])
					st_nxt.req_r[b*8 +: 8] = st_r.req_r[b*8 +: 8]
						& ~pwdata[b*8 +: 8];
		end
		if (wr_acc && hit_ctrl && lanes[0])
			st_nxt.master_r = pwdata[IEC_CTRL_MASTER];
		// acceptance clears its flag and the master gate only
		if (irq_accept)
		begin
			st_nxt.req_r[irq_accept_id] = 1'b0;
			st_nxt.master_r = 1'b0;
		end
		// events set flags whatever the gates; set wins over clear
		st_nxt.req_r = st_nxt.req_r | (events_all & used_mask);
		st_nxt.req_r = st_nxt.req_r & used_mask;
		// captured at the setup edge so it stands from a flop through the
		// single access cycle; a write just before has already landed
		st_nxt.prdata_r = 32'h0000_0000;
		if (setup_phase && !pwrite)
		begin
			if (hit_serial)
				st_nxt.prdata_r[15:0] = serial_en;
			if (hit_analog)
				st_nxt.prdata_r[15:0] = analog_en;
			if (hit_req)
				st_nxt.prdata_r = st_r.req_r;
			if (hit_ctrl)
			begin
				st_nxt.prdata_r[IEC_CTRL_MASTER] = st_r.master_r;
				st_nxt.prdata_r[IEC_CTRL_PEND] = irq_request;
			end
		end
		if (setup_phase && !hit_any)
			st_nxt.pslverr_r = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// zero wait states: data and error come from flops loaded at setup
	assign prdata = st_r.prdata_r;
	assign pready = 1'b1;
	assign pslverr = st_r.pslverr_r;
	assign master_irq_gate = st_r.master_r;
endmodule

/* iec_chk.sv */
// port checks for the interrupt enable register block
`timescale 1ns/1ps
module iec_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iec_pkg::IEC_AW-1:0] paddr,
	input wire logic [iec_pkg::IEC_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [iec_pkg::IEC_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_accept,
	input wire logic irq_request,
	input wire logic master_irq_gate
);
	import iec_pkg::*;
	logic acc;
	logic en_wr;
	assign acc = psel && penable;
	assign en_wr = acc && pwrite &&
		(paddr == IEC_ADDR_ANALOG || paddr == IEC_ADDR_SERIAL);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_zero_wait: assert property (acc |-> pready)
		else $error("access not ready");
	a_unmapped_refused: assert property (acc && paddr == 16'hF000
		|-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	a_mapped_ok: assert property (acc && paddr == IEC_ADDR_ANALOG
		|-> !pslverr) else $error("mapped access refused");
	a_idle_rdata: assert property (!acc |-> prdata == 32'h0)
		else $error("read data outside access");
	a_accept_drops: assert property (irq_accept
		|=> !master_irq_gate && !irq_request) else $error("master kept");
	a_request_gated: assert property (irq_request |-> master_irq_gate)
		else $error("request without master");
	a_write_defers: assert property (en_wr
		|-> !irq_request ##1 !irq_request) else $error("no deferral");
	a_master_store: assert property (acc && pwrite && pstrb[0] &&
		paddr == IEC_ADDR_CTRL && !irq_accept
		|=> master_irq_gate == $past(pwdata[IEC_CTRL_MASTER]))
		else $error("master not stored");
	c_accept: cover property (irq_accept);
	c_refused: cover property (pslverr);
	c_defer: cover property (en_wr ##[1:8] irq_request);
endmodule
bind iec_top iec_chk u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pstrb(pstrb),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.irq_accept(irq_accept),
	.irq_request(irq_request),
	.master_irq_gate(master_irq_gate)
);

/* iec_cpu.sv */
// cpu stand-in: retires instructions and accepts gated requests
`timescale 1ns/1ps
module iec_cpu (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_request,
	input wire logic [4:0] irq_id,
	input wire logic [3:0] lag,
	output logic insn_done,
	output logic irq_accept,
	output logic [4:0] irq_accept_id
);
	logic [3:0] wait_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wait_r <= 4'h0;
			insn_done <= 1'b0;
			irq_accept <= 1'b0;
			irq_accept_id <= 5'h00;
		end
		else
		begin
			// every other cycle, so the deferral window is visible
			insn_done <= !insn_done;
			irq_accept <= 1'b0;
			if (irq_request && !irq_accept && wait_r >= lag)
			begin
				irq_accept <= 1'b1;
				irq_accept_id <= irq_id;
				wait_r <= 4'h0;
			end
			else if (irq_request)
				wait_r <= wait_r + 4'h1;
		end
endmodule

/* tb_iec_top.sv */
// bench for the interrupt enable register block
`timescale 1ns/1ps
module tb_iec_top;
	import iec_pkg::*;
	localparam logic [31:0] USED = {IEC_ANALOG_USED, IEC_SERIAL_USED};
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, insn_done, irq_accept;
	logic pready, pslverr, irq_request, master_irq_gate;
	logic e;
	logic [15:0] paddr, a;
	logic [31:0] pwdata, prdata, ev, q;
	logic [3:0] pstrb, lag;
	logic [4:0] irq_accept_id, irq_id, acc_id;
	int err_count = 0;
	int tests_run = 0;
	int acc_n = 0;
	int n, k;
	iec_top dut (.*, .serial_events(ev[15:0]), .analog_events(ev[31:16]));
	iec_cpu cpu (.*);
	always #5 pclk = !pclk;
	always @(posedge pclk)
		if (irq_accept)
		begin
			acc_n <= acc_n + 1;
			acc_id <= irq_accept_id;
		end
	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic [15:0] ad, input logic w,
		input logic [31:0] d, input logic [3:0] s);
		int t;
		t = 0;
		psel <= 1'b1;
		paddr <= ad;
		pwrite <= w;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 20)
		begin
			@(posedge pclk);
			t++;
		end
		if (pready !== 1'b1)
		begin
			err_count++;
			finish_test;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, ev, lag} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(IEC_ADDR_SERIAL, 0, 0, 0);
		chk("serial reset", q, 0);
		apb(IEC_ADDR_ANALOG, 0, 0, 0);
		chk("analog reset", q, IEC_RST_ENABLE);
		chk("mapped error", e, 0);
		apb(IEC_ADDR_ANALOG, 1, 32'hFFFF, 4'h1);
		apb(IEC_ADDR_ANALOG, 0, 0, 0);
		chk("low byte", q, 32'h00FF);
		apb(IEC_ADDR_ANALOG, 1, 32'hA5A5, 4'h2);
		apb(IEC_ADDR_ANALOG, 0, 0, 0);
		chk("high byte", q, 32'hA5FF);
		apb(IEC_ADDR_SERIAL, 1, 32'hFFFF, 4'h3);
		apb(IEC_ADDR_SERIAL, 0, 0, 0);
		chk("spare bits", q, 32'hFFFF);
		apb(16'hF000, 0, 0, 0);
		chk("unmapped", q, 0);
		chk("unmapped error", e, 1);
		$display("register test done");
		for (int i = 0; i < 32; i++)
		begin
			a = (i < 16) ? IEC_ADDR_SERIAL : IEC_ADDR_ANALOG;
			lag <= 4'(i % 4);
			apb(IEC_ADDR_SERIAL, 1, 0, 4'h3);
			apb(IEC_ADDR_ANALOG, 1, 0, 4'h3);
			apb(IEC_ADDR_CTRL, 1, 1, 4'h1);
			ev <= 32'h1 << i;
			@(posedge pclk);
			ev <= '0;
			apb(IEC_ADDR_REQ, 0, 0, 0);
			chk("flag set", q, 32'(USED[i]) << i);
			n = acc_n;
			apb(a, 1, 32'h1 << (i % 16), 4'h3);
			for (k = 0; k < 40 && acc_n == n; k++)
				@(posedge pclk);
			chk("accepted", acc_n - n, USED[i]);
			if (USED[i])
				chk("source id", acc_id, i);
			apb(IEC_ADDR_CTRL, 0, 0, 0);
			chk("master", q[IEC_CTRL_MASTER], !USED[i]);
			apb(a, 0, 0, 0);
			chk("enable kept", q, 32'h1 << (i % 16));
			apb(IEC_ADDR_REQ, 0, 0, 0);
			chk("flag clear", q, 0);
			$display("source %0d test done", i);
		end
		finish_test;
	end
endmodule
